// *** hdl/utx_pkg.sv ***
package utx_pkg;

    // Byte offsets of the word registers on the bus.
    localparam logic [11:0] UTX_ADDR_PAIR_EXT = 12'h038;
    localparam logic [11:0] UTX_ADDR_PAIR = 12'h03c;
    localparam logic [11:0] UTX_ADDR_FLAG = 12'h040;
    localparam logic [11:0] UTX_ADDR_FLAG_SET = 12'h044;
    localparam logic [11:0] UTX_ADDR_FLAG_CLR = 12'h048;
    localparam logic [11:0] UTX_ADDR_IRQ_EN = 12'h04c;
    localparam logic [11:0] UTX_ADDR_CTRL = 12'h060;
    localparam logic [11:0] UTX_ADDR_STAT = 12'h064;
    localparam int UTX_ADDR_W = 12;

    // Frame fields of the extended pair port.
    localparam int UTX_FIRST_LSB = 0;
    localparam int UTX_SECOND_LSB = 16;
    localparam int UTX_FIRST_CTL_LSB = 11;
    localparam int UTX_SECOND_CTL_LSB = 27;
    localparam int UTX_CTL_W = 5;
    // Frame fields of the plain pair port, eight bits each.
    localparam int UTX_PLAIN_W = 8;
    localparam int UTX_PLAIN_FIRST_LSB = 0;
    localparam int UTX_PLAIN_SECOND_LSB = 8;

    // Bit order inside a five-bit per-frame control slice.
    localparam int UTX_CTL_UNBLOCK = 0;
    localparam int UTX_CTL_TRI = 1;
    localparam int UTX_CTL_BREAK = 2;
    localparam int UTX_CTL_DISABLE = 3;
    localparam int UTX_CTL_RXEN = 4;

    // Flag bit positions, shared by status, set, clear and enable words.
    localparam int UTX_FLAG_W = 13;
    localparam int UTX_F_COLL = 12;
    localparam int UTX_F_SEL_MASTER = 11;
    localparam int UTX_F_ADDR_FRAME = 10;
    localparam int UTX_F_FRAMING = 9;
    localparam int UTX_F_PARITY = 8;
    localparam int UTX_F_TX_UNDER = 7;
    localparam int UTX_F_TX_OVER = 6;
    localparam int UTX_F_RX_UNDER = 5;
    localparam int UTX_F_RX_OVER = 4;
    localparam int UTX_F_RX_FULL = 3;
    localparam int UTX_F_RX_VALID = 2;
    localparam int UTX_F_TX_LEVEL = 1;
    localparam int UTX_F_TX_DONE = 0;
    localparam logic [12:0] UTX_FLAG_RESET = 13'h0002;
    // Bits that software may set or clear; data valid and level excluded.
    localparam logic [12:0] UTX_FLAG_SW_MASK = 13'h1ff9;

    // Own control word layout.
    localparam int UTX_C_TX_EN = 0;
    localparam int UTX_C_RX_EN = 1;
    localparam int UTX_C_TRI = 2;
    localparam int UTX_C_RX_BLOCK = 3;
    localparam int UTX_C_LEVEL_SEL = 4;
    localparam int UTX_CTRL_W = 5;
    localparam logic [4:0] UTX_CTRL_RESET = 5'h00;

    // Transmit buffer depth in frames; one pair write fills it.
    localparam int UTX_DEPTH = 2;
    localparam logic [1:0] UTX_CNT_EMPTY = 2'h0;
    localparam logic [1:0] UTX_CNT_HALF = 2'h1;
    localparam logic [1:0] UTX_CNT_FULL = 2'h2;

endpackage

// *** hdl/utx_tx_irq.sv ***
`timescale 1ns/1ps
// What this block does
// - Extended pair write queues bits 8:0 first.
// - Frame flag sends that frame as break.
// - Frame flag sets tristate control after send.
// - Frame flag clears receiver block after send.
// - Plain pair write queues 7:0 then 15:8.
// - Selected as slave while master raises 11.
// - Address frame received raises flag 10.
// - Framing error raises 9 unless receiver blocked.
// - Parity error raises 8 unless receiver blocked.
// - Slave start without data raises flag 7.
// - Write to non-empty buffer raises 6, discarded.
// - Read of empty receive buffer raises 5.
// - Receive shift register overrun raises flag 4.
// - Receive full raises 3, data valid 2.
// - Level flag resets 1, follows level select.
// - Buffer and shifter empty raises flag 0.
// - Set word sets flags, not 2:1.
// - Clear word clears flags, not 2:1.
// - Enable word holds 13 bits, reset 0.
// - Enable bits 12..0 gate the flags.
module utx_tx_irq
    import utx_pkg::*;
#(
    parameter int FRAME_W = 9
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic tx_frame_valid,
    input wire logic tx_frame_ready,
    output logic [8:0] tx_frame_data,
    output logic tx_frame_break,
    input wire logic tx_done,
    input wire logic ev_collision_fail,
    input wire logic ev_selected_master,
    input wire logic ev_address_frame,
    input wire logic ev_framing_error,
    input wire logic ev_parity_error,
    input wire logic ev_tx_underflow,
    input wire logic ev_rx_underflow,
    input wire logic ev_rx_overflow,
    input wire logic ev_rx_full,
    input wire logic rx_data_avail,
    output logic transmitter_enable,
    output logic receiver_enable,
    output logic transmitter_tristate_ctl,
    output logic receiver_block_ctl,
    output logic irq
);

    // The frame fields are laid out for nine-bit frames only.
    if (FRAME_W != 9) begin : g_bad_width
        $error("utx_tx_irq supports only nine-bit frames");
    end

    // Joins a frame's data and control slice into one buffer word.
    function automatic logic [13:0] pack_frame(input logic [8:0] d,
                                               input logic [4:0] c);
        pack_frame = {c, d};
    endfunction

    // Address phase capture.
    logic ap_wr_r; // A write is in its data phase.
    logic [11:0] ap_addr_r; // Byte address of that write.
    logic ap_take; // Address phase accepted this cycle.
    // Register state.
    logic [12:0] flag_r; // Sticky flags.
    logic [12:0] flag_nxt;
    logic [12:0] ien_r; // Interrupt enables.
    logic [4:0] ctrl_r; // Control word.
    logic [13:0] buf_r [UTX_DEPTH]; // Queued frames, entry 0 leaves first.
    logic [1:0] cnt_r; // Frames in the buffer.
    logic [4:0] cur_ctl_r; // Control slice of the frame in the shifter.
    logic [31:0] hrdata_r;
    logic [31:0] rd_val;
    // Decoded data phase writes.
    logic wr_pair;
    logic wr_pair_ext;
    logic wr_tx;
    logic wr_ok;
    logic tx_over;
    logic pop;
    logic [13:0] first_word;
    logic [13:0] second_word;
    logic [12:0] sw_set;
    logic [12:0] sw_clr;
    logic [12:0] hw_set;
    logic level_hit;

    // The slave never inserts wait states except while frozen.
    assign hreadyout = clk_en;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign ap_take = hsel && htrans[1] && hready;

    // Latch each accepted address phase for its data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r <= 1'b0;
            ap_addr_r <= 12'h000;
        end else if (clk_en && hready) begin
            ap_wr_r <= ap_take && hwrite;
            ap_addr_r <= haddr[UTX_ADDR_W-1:0];
        end
    end

    // Data phase write decoding.
    always_comb begin
        wr_pair = 1'b0;
        wr_pair_ext = 1'b0;
        sw_set = 13'h0000;
        sw_clr = 13'h0000;
        if (!ap_wr_r) begin
            // No write pending.
        end else if (ap_addr_r == UTX_ADDR_PAIR) begin
            wr_pair = 1'b1;
        end else if (ap_addr_r == UTX_ADDR_PAIR_EXT) begin
            wr_pair_ext = 1'b1;
        end else if (ap_addr_r == UTX_ADDR_FLAG_SET) begin
            sw_set = hwdata[UTX_FLAG_W-1:0] & UTX_FLAG_SW_MASK;
        end else if (ap_addr_r == UTX_ADDR_FLAG_CLR) begin
            sw_clr = hwdata[UTX_FLAG_W-1:0] & UTX_FLAG_SW_MASK;
        end
    end

    assign wr_tx = wr_pair || wr_pair_ext;
    // A pair needs the whole buffer, so it goes in only when empty.
    assign wr_ok = wr_tx && (cnt_r == UTX_CNT_EMPTY);
    assign tx_over = wr_tx && (cnt_r != UTX_CNT_EMPTY);

    // Split the written word into two frames; plain writes clear control.
    always_comb begin
        if (wr_pair_ext) begin
            first_word = pack_frame(
                hwdata[UTX_FIRST_LSB +: FRAME_W],
                hwdata[UTX_FIRST_CTL_LSB +: UTX_CTL_W]);
            second_word = pack_frame(
                hwdata[UTX_SECOND_LSB +: FRAME_W],
                hwdata[UTX_SECOND_CTL_LSB +: UTX_CTL_W]);
        end else begin
            first_word = pack_frame(
                {1'b0, hwdata[UTX_PLAIN_FIRST_LSB +: UTX_PLAIN_W]}, 5'h00);
            second_word = pack_frame(
                {1'b0, hwdata[UTX_PLAIN_SECOND_LSB +: UTX_PLAIN_W]}, 5'h00);
        end
    end

    // Frames leave only while the transmitter is enabled.
    assign tx_frame_valid = clk_en && (cnt_r != UTX_CNT_EMPTY)
                            && ctrl_r[UTX_C_TX_EN];
    assign pop = tx_frame_valid && tx_frame_ready;
    assign tx_frame_data = buf_r[0][FRAME_W-1:0];
    // The break request travels with the frame itself.
    assign tx_frame_break = buf_r[0][FRAME_W + UTX_CTL_BREAK];

    // Transmit buffer; an overflowing write leaves its contents alone.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_r[0] <= 14'h0000;
            buf_r[1] <= 14'h0000;
            cnt_r <= UTX_CNT_EMPTY;
        end else if (clk_en) begin
            if (wr_ok) begin
                // The first frame sits at the head and goes out first.
                buf_r[0] <= first_word;
                buf_r[1] <= second_word;
                cnt_r <= UTX_CNT_FULL;
            end else if (pop) begin
                buf_r[0] <= buf_r[1];
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end

    // Remember the control slice of the frame now being shifted out.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ctl_r <= 5'h00;
        end else if (clk_en && pop) begin
            cur_ctl_r <= buf_r[0][FRAME_W +: UTX_CTL_W];
        end
    end

    // Control word: software writes it, finished frames act on it after.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= UTX_CTRL_RESET;
        end else if (clk_en) begin
            if (ap_wr_r && ap_addr_r == UTX_ADDR_CTRL) begin
                ctrl_r <= hwdata[UTX_CTRL_W-1:0];
            end
            // A finished frame's actions win over a write in the same cycle.
            if (tx_done) begin
                if (cur_ctl_r[UTX_CTL_RXEN]) begin
                    ctrl_r[UTX_C_RX_EN] <= 1'b1;
                end
                if (cur_ctl_r[UTX_CTL_DISABLE]) begin
                    ctrl_r[UTX_C_TX_EN] <= 1'b0;
                end
                if (cur_ctl_r[UTX_CTL_TRI]) begin
                    ctrl_r[UTX_C_TRI] <= 1'b1;
                end
                if (cur_ctl_r[UTX_CTL_UNBLOCK]) begin
                    ctrl_r[UTX_C_RX_BLOCK] <= 1'b0;
                end
            end
        end
    end

    assign transmitter_enable = ctrl_r[UTX_C_TX_EN];
    assign receiver_enable = ctrl_r[UTX_C_RX_EN];
    // Releasing the line after a disable is done by raising tristate too.
    assign transmitter_tristate_ctl = ctrl_r[UTX_C_TRI]
                                      || !ctrl_r[UTX_C_TX_EN];
    assign receiver_block_ctl = ctrl_r[UTX_C_RX_BLOCK];

    // Level flag: empty, or at most half full when the select is set.
    assign level_hit = ctrl_r[UTX_C_LEVEL_SEL] ?
                       (cnt_r <= UTX_CNT_HALF) : (cnt_r == UTX_CNT_EMPTY);

    // Hardware events; framing and parity flags are held off while receive is blocked.
    always_comb begin
        hw_set = 13'h0000;
        hw_set[UTX_F_COLL] = ev_collision_fail;
        hw_set[UTX_F_SEL_MASTER] = ev_selected_master;
        hw_set[UTX_F_ADDR_FRAME] = ev_address_frame;
        hw_set[UTX_F_FRAMING] = ev_framing_error
                                && !ctrl_r[UTX_C_RX_BLOCK];
        hw_set[UTX_F_PARITY] = ev_parity_error
                               && !ctrl_r[UTX_C_RX_BLOCK];
        hw_set[UTX_F_TX_UNDER] = ev_tx_underflow;
        hw_set[UTX_F_TX_OVER] = tx_over;
        hw_set[UTX_F_RX_UNDER] = ev_rx_underflow;
        hw_set[UTX_F_RX_OVER] = ev_rx_overflow;
        hw_set[UTX_F_RX_FULL] = ev_rx_full;
        // Done with nothing left queued means buffer and shifter are empty.
        hw_set[UTX_F_TX_DONE] = tx_done && (cnt_r == UTX_CNT_EMPTY);
    end

    // Sticky flags: a set arriving with a clear wins.
    always_comb begin
        flag_nxt = (flag_r & ~sw_clr) | sw_set | hw_set;
        flag_nxt[UTX_F_RX_VALID] = rx_data_avail;
        flag_nxt[UTX_F_TX_LEVEL] = level_hit;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= UTX_FLAG_RESET;
        end else if (clk_en) begin
            flag_r <= flag_nxt;
        end
    end

    // Enable word; every bit is plain read-write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ien_r <= 13'h0000;
        end else if (clk_en && ap_wr_r && ap_addr_r == UTX_ADDR_IRQ_EN) begin
            ien_r <= hwdata[UTX_FLAG_W-1:0];
        end
    end

    assign irq = |(flag_r & ien_r);

    // Read multiplexer; write-only and unmapped words read as zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr[UTX_ADDR_W-1:0] == UTX_ADDR_FLAG) begin
            rd_val[UTX_FLAG_W-1:0] = flag_r;
        end else if (haddr[UTX_ADDR_W-1:0] == UTX_ADDR_IRQ_EN) begin
            rd_val[UTX_FLAG_W-1:0] = ien_r;
        end else if (haddr[UTX_ADDR_W-1:0] == UTX_ADDR_CTRL) begin
            rd_val[UTX_CTRL_W-1:0] = ctrl_r;
        end else if (haddr[UTX_ADDR_W-1:0] == UTX_ADDR_STAT) begin
            rd_val[1:0] = cnt_r;
        end
    end

    // Read data is fetched at the address phase so it stands from a flop.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (clk_en && ap_take && !hwrite) begin
            hrdata_r <= rd_val;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_over_flags: assert property (
        clk_en && tx_over |=> flag_r[UTX_F_TX_OVER])
        else $error("overflow flag not raised");

    a_over_keeps: assert property (
        clk_en && tx_over && !pop |=> cnt_r == $past(cnt_r)
            && buf_r[0] == $past(buf_r[0]))
        else $error("overflowing write changed the buffer");

    a_pair_order: assert property (
        clk_en && wr_ok && wr_pair_ext |=> cnt_r == UTX_CNT_FULL
            && buf_r[0][8:0] == $past(hwdata[8:0])
            && buf_r[1][8:0] == $past(hwdata[24:16]))
        else $error("extended pair queued in wrong order");

    a_plain_order: assert property (
        clk_en && wr_ok && wr_pair |=> buf_r[0] == {6'h00, $past(hwdata[7:0])}
            && buf_r[1] == {6'h00, $past(hwdata[15:8])})
        else $error("plain pair queued wrongly");

    a_level_empty: assert property (
        clk_en && !ctrl_r[UTX_C_LEVEL_SEL] && cnt_r == UTX_CNT_FULL
            |=> !flag_r[UTX_F_TX_LEVEL])
        else $error("level flag set with full buffer");

    a_set_wins: assert property (
        clk_en && ev_collision_fail && sw_clr[UTX_F_COLL]
            |=> flag_r[UTX_F_COLL])
        else $error("event lost to a clear");

    a_clear_works: assert property (
        clk_en && sw_clr[UTX_F_COLL] && !hw_set[UTX_F_COLL]
            && !sw_set[UTX_F_COLL] |=> !flag_r[UTX_F_COLL])
        else $error("clear did not clear");

    a_block_framing: assert property (
        clk_en && ev_framing_error && ctrl_r[UTX_C_RX_BLOCK]
            && !flag_r[UTX_F_FRAMING] && !sw_set[UTX_F_FRAMING]
            |=> !flag_r[UTX_F_FRAMING])
        else $error("framing flag set while blocked");

    a_disable_after: assert property (
        clk_en && tx_done && cur_ctl_r[UTX_CTL_DISABLE]
            |=> !transmitter_enable ##0 transmitter_tristate_ctl)
        else $error("transmitter not disabled after frame");

    a_irq_follow: assert property (
        clk_en && ap_wr_r && ap_addr_r == UTX_ADDR_IRQ_EN
            && (hwdata[12:0] & flag_nxt) != 13'h0000 |=> irq)
        else $error("enabled flag gives no interrupt");

endmodule

// *** tb/usart_tx_write_and_irq_flags_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the pair write ports and the flag logic.
module usart_tx_write_and_irq_flags_tb
    import utx_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, rx_data_avail, stall;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [3:0] gap;
    logic [8:0] ev, tx_frame_data;
    logic hreadyout, tx_frame_valid, tx_frame_ready, tx_frame_break;
    logic tx_done, te, re, tx_tri, rb, irq, hresp;
    wire logic hready;
    // Frames taken by the core, break bit above the data.
    logic [9:0] frames[$];
    int n_fail, cmp_count;
    // Flag bit raised by each event line, in the order of ev.
    int fb[9] = '{UTX_F_COLL, UTX_F_SEL_MASTER, UTX_F_ADDR_FRAME,
        UTX_F_FRAMING, UTX_F_PARITY, UTX_F_TX_UNDER, UTX_F_RX_UNDER,
        UTX_F_RX_OVER, UTX_F_RX_FULL};

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    utx_tx_irq dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tx_frame_valid(tx_frame_valid),
        .tx_frame_ready(tx_frame_ready), .tx_frame_data(tx_frame_data),
        .tx_frame_break(tx_frame_break), .tx_done(tx_done),
        .ev_collision_fail(ev[0]), .ev_selected_master(ev[1]),
        .ev_address_frame(ev[2]), .ev_framing_error(ev[3]),
        .ev_parity_error(ev[4]), .ev_tx_underflow(ev[5]),
        .ev_rx_underflow(ev[6]), .ev_rx_overflow(ev[7]),
        .ev_rx_full(ev[8]), .rx_data_avail(rx_data_avail),
        .transmitter_enable(te), .receiver_enable(re),
        .transmitter_tristate_ctl(tx_tri), .receiver_block_ctl(rb),
        .irq(irq));

    utx_core_model core (.hclk(hclk), .hresetn(hresetn), .stall(stall),
        .gap(gap), .tx_frame_valid(tx_frame_valid),
        .tx_frame_ready(tx_frame_ready), .tx_done(tx_done));

    // The clock runs at 50 MHz.
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Every frame taken at an edge is logged as the design saw it.
    always @(posedge hclk) begin
        if (tx_frame_valid === 1'b1 && tx_frame_ready === 1'b1) begin
            frames.push_back({tx_frame_break, tx_frame_data});
        end
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One single word transfer; each phase is held until ready is seen.
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        rdat = hrdata;
        // Let the updates of the closing edge land before anyone looks.
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
        input string nm);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, x, e);
    endtask

    // Waits for the end of a frame, bounded so a silent core is caught.
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (tx_done !== 1'b1 && n < 200);
        chk("done seen", 32'(n < 200), 32'h1);
        #1;
    endtask

    // A one-cycle pulse on one event line.
    task automatic pulse(input int i);
        @(posedge hclk);
        ev <= 9'(1 << i);
        @(posedge hclk);
        ev <= 9'h0;
    endtask

    task automatic t_reset;
        rdchk(UTX_ADDR_FLAG, 32'h2, "flag reset");
        rdchk(UTX_ADDR_IRQ_EN, 32'h0, "enable reset");
        rdchk(UTX_ADDR_FLAG_CLR, 32'h0, "clear word read");
        chk("irq reset", 32'(irq), 32'h0);
        chk("okay response", 32'(hresp), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_irq;
        wr(UTX_ADDR_IRQ_EN, 32'hffffffff);
        rdchk(UTX_ADDR_IRQ_EN, 32'h1fff, "enable width");
        rdchk(12'h100, 32'h0, "unmapped read");
        wr(UTX_ADDR_IRQ_EN, 32'h1);
        wr(UTX_ADDR_FLAG_SET, 32'h1fff);
        rdchk(UTX_ADDR_FLAG, 32'h1ffb, "flags set");
        chk("irq on", 32'(irq), 32'h1);
        wr(UTX_ADDR_FLAG_CLR, 32'h1ffe);
        rdchk(UTX_ADDR_FLAG, 32'h3, "flags cleared");
        chk("irq kept", 32'(irq), 32'h1);
        wr(UTX_ADDR_FLAG_CLR, 32'h1);
        chk("irq off", 32'(irq), 32'h0);
        wr(UTX_ADDR_IRQ_EN, 32'h2);
        chk("irq level", 32'(irq), 32'h1);
        wr(UTX_ADDR_IRQ_EN, 32'h0);
        $display("test irq done");
    endtask

    task automatic t_events;
        for (int i = 0; i < 9; i++) begin
            pulse(i);
            rdchk(UTX_ADDR_FLAG, 32'(1 << fb[i]) | 32'h2, "event");
            wr(UTX_ADDR_FLAG_CLR, 32'h1fff);
        end
        // An event in the very cycle of a clear must survive the clear.
        fork
            wr(UTX_ADDR_FLAG_CLR, 32'h1000);
            begin
                repeat (2) @(posedge hclk);
                ev <= 9'h1;
                @(posedge hclk);
                ev <= 9'h0;
            end
        join
        rdchk(UTX_ADDR_FLAG, 32'h1002, "set beats clear");
        wr(UTX_ADDR_FLAG_CLR, 32'h1fff);
        // A blocked receiver must not flag framing or parity faults.
        wr(UTX_ADDR_CTRL, 32'h8);
        pulse(3);
        pulse(4);
        rdchk(UTX_ADDR_FLAG, 32'h2, "blocked errors");
        wr(UTX_ADDR_CTRL, 32'h0);
        @(posedge hclk);
        rx_data_avail <= 1'b1;
        @(posedge hclk);
        rdchk(UTX_ADDR_FLAG, 32'h6, "data valid");
        @(posedge hclk);
        rx_data_avail <= 1'b0;
        $display("test events done");
    endtask

    task automatic t_plain;
        @(posedge hclk);
        stall <= 1'b1;
        gap <= 4'hf;
        frames.delete();
        wr(UTX_ADDR_CTRL, 32'h1);
        wr(UTX_ADDR_PAIR, 32'h0000a55a);
        rdchk(UTX_ADDR_STAT, 32'h2, "count");
        rdchk(UTX_ADDR_FLAG, 32'h0, "level full");
        // A second pair into the full buffer is refused and flagged.
        wr(UTX_ADDR_PAIR, 32'h00001234);
        rdchk(UTX_ADDR_FLAG, 32'h40, "overflow");
        @(posedge hclk);
        stall <= 1'b0;
        // One frame left on a slow line: with the select set, level rises.
        wr(UTX_ADDR_CTRL, 32'h11);
        rdchk(UTX_ADDR_FLAG, 32'h42, "level half");
        wait_done;
        wait_done;
        chk("frame count", 32'(frames.size()), 32'h2);
        chk("plain first", 32'(frames[0]), 32'h05a);
        chk("plain second", 32'(frames[1]), 32'h0a5);
        rdchk(UTX_ADDR_FLAG, 32'h43, "complete");
        wr(UTX_ADDR_FLAG_CLR, 32'h1fff);
        $display("test plain done");
    endtask

    task automatic t_ext;
        @(posedge hclk);
        gap <= 4'h6;
        frames.delete();
        wr(UTX_ADDR_CTRL, 32'h9);
        // First: break, tristate, unblock; second: rx enable, tx off.
        wr(UTX_ADDR_PAIR_EXT, 32'hc0c339a5);
        wait_done;
        chk("unblocked", 32'(rb), 32'h0);
        chk("tristate", 32'(tx_tri), 32'h1);
        chk("tx still on", 32'(te), 32'h1);
        chk("rx still off", 32'(re), 32'h0);
        wait_done;
        chk("tx off", 32'(te), 32'h0);
        chk("rx on", 32'(re), 32'h1);
        chk("ext first", 32'(frames[0]), 32'h3a5);
        chk("ext second", 32'(frames[1]), 32'h0c3);
        rdchk(UTX_ADDR_CTRL, 32'h6, "ctrl after");
        $display("test extended done");
    endtask

    // The one place where the run ends.
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The tests need well under a thousand cycles; this cuts a hang short.
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ev = 9'h0;
        rx_data_avail = 1'b0;
        stall = 1'b0;
        gap = 4'h1;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_irq();
        t_events();
        t_plain();
        t_ext();
        stop_test();
    end
endmodule

// *** tb/utx_core_model.sv ***
`timescale 1ns/1ps
// Behavioural serial core: it takes one frame at a time and reports its end.
module utx_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic stall,
    input wire logic [3:0] gap,
    input wire logic tx_frame_valid,
    output logic tx_frame_ready,
    output logic tx_done
);
    // Cycles left of the frame now being shifted out.
    logic [3:0] left_r;
    // High while a frame is on the line.
    logic busy_r;

    // Ready is offered only while idle, so a frame is never taken twice.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_frame_ready <= 1'b0;
            busy_r <= 1'b0;
            left_r <= 4'h0;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (tx_frame_valid && tx_frame_ready) begin
                // The frame is taken; a slow line is modelled by the gap.
                tx_frame_ready <= 1'b0;
                busy_r <= 1'b1;
                left_r <= gap;
            end else if (busy_r) begin
                if (left_r == 4'h0) begin
                    busy_r <= 1'b0;
                    tx_done <= 1'b1;
                end else begin
                    left_r <= left_r - 4'h1;
                end
            end else begin
                // A stalled core holds the buffer full.
                tx_frame_ready <= !stall;
            end
        end
    end
endmodule
